// ==== hw/otpf_defs.svh ====
`ifndef OTPF_DEFS_SVH
`define OTPF_DEFS_SVH

// ----------------------------------------------------------------
// line timing
// ----------------------------------------------------------------
`define OTPF_SYS_KHZ 17'h1_E848
`define OTPF_BITS_PER_FRAME 256
`define OTPF_FRAME_HZ 8000
`define OTPF_LINE_KBPS (`OTPF_BITS_PER_FRAME * `OTPF_FRAME_HZ / 1000)
`define OTPF_LINE_STEP 17'(`OTPF_LINE_KBPS)
`define OTPF_MODE_SETTLE 2'h2

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define OTPF_LAST_BIT 8'hFF
`define OTPF_FAS_END 8'h07
`define OTPF_PAY_END 8'h0F
`define OTPF_TS_ALIGN 5'h00
`define OTPF_TS_PAYLOAD 5'h01
`define OTPF_FAS 7'h1B
`define OTPF_IDLE 8'hFF
`define OTPF_BUF_DEPTH 2

`endif

// ==== hw/otpf_pkg.sv ====
package otpf_pkg;

  typedef logic [7:0] otpf_byte_type;

  typedef struct packed {
    otpf_byte_type [1:0] mem;
    logic wrIdx;
    logic rdIdx;
    logic [1:0] count;
  } otpf_buf_state_type;

  typedef struct packed {
    logic [1:0] modeSync;
    logic [1:0] rxClkSync;
    logic [1:0] rxDatSync;
    logic rxClkLast;
    logic modeTaken;
    logic [1:0] modeWait;
    logic looped;
    logic [16:0] acc;
    logic [7:0] txBit;
    logic txOdd;
    otpf_byte_type txPay;
    logic txLine;
    logic txFrame;
    logic [7:0] rxHist;
    logic [7:0] rxBit;
    logic rxOdd;
    logic rxLocked;
    otpf_byte_type rxByte;
    logic rxValid;
  } otpf_chan_state_type;

endpackage

// ==== hw/otpf_framer.sv ====
`timescale 1ns/1ps
`include "otpf_defs.svh"

// ----------------------------------------------------------------
// two-entry payload buffer
// ----------------------------------------------------------------
module otpf_buffer
  import otpf_pkg::*;
(
  // clock and reset
  input wire logic sysClk,
  input wire logic rstSyncB,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire otpf_byte_type inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output otpf_byte_type outData
);
  otpf_buf_state_type s_q;
  otpf_buf_state_type s_d;
  logic push;
  logic pop;

  assign inReady = (s_q.count != 2'(`OTPF_BUF_DEPTH));
  assign outValid = (s_q.count != 2'h0);
  assign outData = s_q.mem[s_q.rdIdx];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wrIdx] = inData;
      s_d.wrIdx = ~s_q.wrIdx;
    end
    if (pop) begin
      s_d.rdIdx = ~s_q.rdIdx;
    end
    s_d.count = s_q.count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge sysClk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ----------------------------------------------------------------
// one channel: timing select, framer, aligner
// ----------------------------------------------------------------
module otpf_channel
  import otpf_pkg::*;
(
  // clock and reset
  input wire logic sysClk,
  input wire logic rstSyncB,
  // pins
  input wire logic loopedPin,
  input wire logic rxClkPin,
  input wire logic rxDataPin,
  output logic txLine,
  // payload in
  input wire logic payValid,
  output logic payTake,
  input wire otpf_byte_type payData,
  // status and receive
  output logic txFrame,
  output logic loopedMode,
  output logic rxLocked,
  output otpf_byte_type rxByte,
  output logic rxValid
);
  otpf_chan_state_type s_q;
  otpf_chan_state_type s_d;
  logic rxTick;
  logic intTick;
  logic txTick;
  logic [16:0] accSum;
  logic [4:0] slot;
  logic [2:0] pos;
  logic [7:0] nextBit;
  logic nextOdd;
  logic lineBit;
  logic [7:0] hist;
  logic [6:0] fasPat;

  assign fasPat = `OTPF_FAS;
  assign rxTick = s_q.rxClkSync[1] & ~s_q.rxClkLast;
  assign accSum = s_q.acc + `OTPF_LINE_STEP;
  assign intTick = (accSum >= `OTPF_SYS_KHZ);
  // no bits leave before the mode is known
  assign txTick = s_q.modeTaken
    & (s_q.looped ? rxTick : intTick);
  assign nextBit = s_q.txBit + 8'h01;
  assign nextOdd = (s_q.txBit == `OTPF_LAST_BIT) ? ~s_q.txOdd : s_q.txOdd;
  assign slot = nextBit[7:3];
  assign pos = nextBit[2:0];
  assign hist = {s_q.rxHist[6:0], s_q.rxDatSync[1]};
  assign payTake = txTick & (s_q.txBit == `OTPF_LAST_BIT) & payValid;

  // one payload slot per frame, one alignment slot with the FAS in even frames only (ones in odd frames), all others idle ones
  always_comb begin
    lineBit = 1'b1;
    if (slot == `OTPF_TS_ALIGN) begin
      if (!nextOdd && pos != 3'h0) begin
        lineBit = fasPat[3'h7 - pos];
      end
    end else if (slot == `OTPF_TS_PAYLOAD) begin
      // byte latched at frame start, so a late push cannot tear it
      lineBit = s_q.txPay[3'h7 - pos];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.modeSync = {s_q.modeSync[0], loopedPin};
    s_d.rxClkSync = {s_q.rxClkSync[0], rxClkPin};
    s_d.rxDatSync = {s_q.rxDatSync[0], rxDataPin};
    s_d.rxClkLast = s_q.rxClkSync[1];
    s_d.rxValid = 1'b0;
    s_d.txFrame = 1'b0;
    // static strap: changing it later would glitch the link
    // wait until the strap has crossed both synchroniser stages
    if (!s_q.modeTaken) begin
      if (s_q.modeWait != `OTPF_MODE_SETTLE) begin
        s_d.modeWait = s_q.modeWait + 2'h1;
      end else begin
        s_d.looped = s_q.modeSync[1];
        s_d.modeTaken = 1'b1;
      end
    end
    s_d.acc = intTick ? accSum - `OTPF_SYS_KHZ : accSum;
    if (txTick) begin
      s_d.txBit = nextBit;
      s_d.txOdd = nextOdd;
      s_d.txLine = lineBit;
      if (s_q.txBit == `OTPF_LAST_BIT) begin
        s_d.txPay = payValid ? payData : `OTPF_IDLE;
        s_d.txFrame = 1'b1;
      end
    end
    if (rxTick) begin
      s_d.rxHist = hist;
      s_d.rxBit = s_q.rxBit + 8'h01;
      if (s_q.rxBit + 8'h01 == `OTPF_LAST_BIT + 8'h00) begin
        s_d.rxBit = `OTPF_LAST_BIT;
      end
      if (!s_q.rxLocked) begin
        if (hist[6:0] == `OTPF_FAS) begin
          s_d.rxLocked = 1'b1;
          s_d.rxBit = `OTPF_FAS_END;
          s_d.rxOdd = 1'b0;
        end
      end else begin
        if (s_q.rxBit == `OTPF_LAST_BIT) begin
          s_d.rxOdd = ~s_q.rxOdd;
        end
        if (s_q.rxBit + 8'h01 == `OTPF_FAS_END && !s_q.rxOdd
            && s_q.rxBit != `OTPF_LAST_BIT
            && hist[6:0] != `OTPF_FAS) begin
          s_d.rxLocked = 1'b0;
        end
        if (s_q.rxBit + 8'h01 == `OTPF_PAY_END) begin
          s_d.rxByte = hist;
          s_d.rxValid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sysClk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign txLine = s_q.txLine;
  assign txFrame = s_q.txFrame;
  assign loopedMode = s_q.looped;
  assign rxLocked = s_q.rxLocked;
  assign rxByte = s_q.rxByte;
  assign rxValid = s_q.rxValid;
endmodule

// ----------------------------------------------------------------
// top: reset release and two independent channels
// ----------------------------------------------------------------
module otpf_framer
  import otpf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // channel 1 pins and user side
  input wire logic ch1LoopedPin,
  input wire logic ch1RxClk,
  input wire logic ch1RxData,
  output logic ch1TxLine,
  input wire logic ch1InValid,
  output logic ch1InReady,
  input wire otpf_byte_type ch1InData,
  output logic ch1TxFrame,
  output logic ch1Looped,
  output logic ch1RxLocked,
  output otpf_byte_type ch1RxByte,
  output logic ch1RxValid,
  // channel 2 pins and user side
  input wire logic ch2LoopedPin,
  input wire logic ch2RxClk,
  input wire logic ch2RxData,
  output logic ch2TxLine,
  input wire logic ch2InValid,
  output logic ch2InReady,
  input wire otpf_byte_type ch2InData,
  output logic ch2TxFrame,
  output logic ch2Looped,
  output logic ch2RxLocked,
  output otpf_byte_type ch2RxByte,
  output logic ch2RxValid
);
  logic [1:0] rstSync_q;
  logic rstSyncB;
  logic [1:0] bufValid;
  logic [1:0] bufTake;
  otpf_byte_type [1:0] bufData;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstSyncB = rstSync_q[1];

  otpf_buffer u_buf1 (
    .sysClk(sys_clk), .rstSyncB(rstSyncB),
    .inValid(ch1InValid), .inReady(ch1InReady), .inData(ch1InData),
    .outValid(bufValid[0]), .outReady(bufTake[0]), .outData(bufData[0])
  );
  otpf_buffer u_buf2 (
    .sysClk(sys_clk), .rstSyncB(rstSyncB),
    .inValid(ch2InValid), .inReady(ch2InReady), .inData(ch2InData),
    .outValid(bufValid[1]), .outReady(bufTake[1]), .outData(bufData[1])
  );

  otpf_channel u_ch1 (
    .sysClk(sys_clk), .rstSyncB(rstSyncB),
    .loopedPin(ch1LoopedPin), .rxClkPin(ch1RxClk),
    .rxDataPin(ch1RxData), .txLine(ch1TxLine),
    .payValid(bufValid[0]), .payTake(bufTake[0]), .payData(bufData[0]),
    .txFrame(ch1TxFrame), .loopedMode(ch1Looped),
    .rxLocked(ch1RxLocked), .rxByte(ch1RxByte), .rxValid(ch1RxValid)
  );
  otpf_channel u_ch2 (
    .sysClk(sys_clk), .rstSyncB(rstSyncB),
    .loopedPin(ch2LoopedPin), .rxClkPin(ch2RxClk),
    .rxDataPin(ch2RxData), .txLine(ch2TxLine),
    .payValid(bufValid[1]), .payTake(bufTake[1]), .payData(bufData[1]),
    .txFrame(ch2TxFrame), .loopedMode(ch2Looped),
    .rxLocked(ch2RxLocked), .rxByte(ch2RxByte), .rxValid(ch2RxValid)
  );
endmodule

// ==== dv/otpf_far_end.sv ====
`timescale 1ns/1ps
// ----
// far end: free-running line source
// ----
module otpf_far_end #(parameter int HALF = 32) (
  // line pins
  output logic rxClk,
  output logic rxData,
  // timeslot 1 byte
  input wire logic [7:0] nextByte,
  output logic [7:0] sentByte
);
  localparam logic [7:0] FAS = 8'h9B;
  int b;
  bit odd;
  initial begin
    rxClk = 1'b0;
    rxData = 1'b1;
    sentByte = 8'h00;
    odd = 1'b0;
    forever begin
      for (b = 0; b < 256; b++) begin
        if (b == 0) sentByte = nextByte;
        rxData = (b < 8) ? (odd | FAS[7-b])
               : (b < 16) ? sentByte[15-b] : 1'b1;
        #(HALF * 8) rxClk = 1'b1;
        #(HALF * 8) rxClk = 1'b0;
      end
      odd = !odd;
    end
  end
endmodule

// ==== dv/otpf_framer_assertions.sv ====
`timescale 1ns/1ps
// ----
// port checks
// ----
module otpf_framer_assertions
  import otpf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // channel 1
  input wire logic ch1TxLine,
  input wire logic ch1TxFrame,
  input wire logic ch1Looped,
  input wire logic ch1RxLocked,
  input wire otpf_byte_type ch1RxByte,
  input wire logic ch1RxValid,
  // channel 2
  input wire logic ch2TxLine,
  input wire logic ch2TxFrame,
  input wire logic ch2Looped,
  input wire logic ch2RxValid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [14:0] gap_q;
  logic seen_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 15'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= ch1TxFrame ? 15'h0001 : gap_q + 15'h0001;
      seen_q <= seen_q | ch1TxFrame;
    end
  end
  AST_FRAME_GAP: assert property (ch1TxFrame && seen_q && !ch1Looped
    |-> gap_q inside {[15624:15626]}) else $error("frame period off");
  AST_FRAME_ONE: assert property (ch1TxFrame |=> !ch1TxFrame)
    else $error("frame pulse too long");
  AST_FRAME_BIT0: assert property (ch1TxFrame |-> ch1TxLine)
    else $error("frame bit 0 not one");
  AST_BIT_HOLD: assert property ($changed(ch1TxLine) && !ch1Looped
    |=> $stable(ch1TxLine)[*8]) else $error("line bit too short");
  AST_MODE_HOLD: assert property (ch2Looped |=> ch2Looped)
    else $error("timing mode changed");
  AST_CH2_FRAME: assert property (ch2TxFrame |=> !ch2TxFrame)
    else $error("ch2 frame pulse too long");
  AST_RX_LOCK: assert property (ch1RxValid |-> ch1RxLocked)
    else $error("byte without lock");
  AST_RX_BYTE: assert property ($changed(ch1RxByte) |-> ch1RxValid)
    else $error("byte changed silently");
  AST_RX_PULSE: assert property (ch2RxValid |=> !ch2RxValid)
    else $error("rx valid too long");
  AST_CH2_BIT0: assert property (ch2TxFrame |-> ch2TxLine)
    else $error("ch2 frame bit 0 not one");
  AST_CH1_MODE: assert property (!ch1Looped |=> !ch1Looped)
    else $error("ch1 timing mode changed");
  cover property (ch1TxFrame);
  cover property (ch1RxValid);
  cover property (ch2RxValid);
endmodule
bind otpf_framer otpf_framer_assertions u_otpf_framer_assertions (
  .sys_clk(sys_clk), .rst_b(rst_b),
  .ch1TxLine(ch1TxLine), .ch1TxFrame(ch1TxFrame), .ch1Looped(ch1Looped),
  .ch1RxLocked(ch1RxLocked), .ch1RxByte(ch1RxByte),
  .ch1RxValid(ch1RxValid), .ch2TxLine(ch2TxLine),
  .ch2TxFrame(ch2TxFrame), .ch2Looped(ch2Looped), .ch2RxValid(ch2RxValid)
);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
// ----
// framer bench
// ----
module tb_top
  import otpf_pkg::*;
;
  logic sys_clk, rst_b, ch1LoopedPin, ch2LoopedPin, ch1InValid, ch2InValid;
  logic ch1RxClk, ch1RxData, ch2RxClk, ch2RxData, ch1TxLine, ch2TxLine;
  logic ch1InReady, ch2InReady, ch1TxFrame, ch2TxFrame, ch1Looped;
  logic ch2Looped, ch1RxLocked, ch2RxLocked, ch1RxValid, ch2RxValid;
  otpf_byte_type ch1InData, ch2InData, ch1RxByte, ch2RxByte;
  logic [7:0] sent1, sent2, next1, next2, a;
  int mismatches, cmp_count, nfr, evenBase, gap2, i;
  otpf_framer u_otpf_framer (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .ch1LoopedPin(ch1LoopedPin), .ch1RxClk(ch1RxClk),
    .ch1RxData(ch1RxData), .ch1TxLine(ch1TxLine),
    .ch1InValid(ch1InValid), .ch1InReady(ch1InReady),
    .ch1InData(ch1InData), .ch1TxFrame(ch1TxFrame),
    .ch1Looped(ch1Looped), .ch1RxLocked(ch1RxLocked),
    .ch1RxByte(ch1RxByte), .ch1RxValid(ch1RxValid),
    .ch2LoopedPin(ch2LoopedPin), .ch2RxClk(ch2RxClk),
    .ch2RxData(ch2RxData), .ch2TxLine(ch2TxLine),
    .ch2InValid(ch2InValid), .ch2InReady(ch2InReady),
    .ch2InData(ch2InData), .ch2TxFrame(ch2TxFrame),
    .ch2Looped(ch2Looped), .ch2RxLocked(ch2RxLocked),
    .ch2RxByte(ch2RxByte), .ch2RxValid(ch2RxValid)
  );
  otpf_far_end #(.HALF(31)) u_otpf_far_end_1 (.rxClk(ch1RxClk),
    .rxData(ch1RxData), .nextByte(next1), .sentByte(sent1));
  otpf_far_end #(.HALF(32)) u_otpf_far_end_2 (.rxClk(ch2RxClk),
    .rxData(ch2RxData), .nextByte(next2), .sentByte(sent2));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_frame;
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (ch1TxFrame !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic push(input logic [7:0] b);
    int n;
    @(posedge sys_clk);
    ch1InValid <= 1'b1;
    ch1InData <= b;
    for (n = 0; n < 99 && ch1InReady !== 1'b1; n++) @(negedge sys_clk);
    if (n >= 99) begin
      mismatches++;
      report_and_stop();
    end
    @(posedge sys_clk);
    ch1InValid <= 1'b0;
  endtask
  // mid-bit sampling against the average bit spacing
  task automatic frame_check(input logic [7:0] b);
    logic [15:0] got;
    int k;
    int cyc;
    cyc = 0;
    wait_frame();
    for (k = 0; k < 16; k++) begin
      repeat (k * 125000 / 2048 + 30 - cyc) @(negedge sys_clk);
      cyc = k * 125000 / 2048 + 30;
      got[15-k] = ch1TxLine;
    end
    if (evenBase < 0) evenBase = (got[15:8] == 8'h9B) ? nfr : nfr + 1;
    chk("ts0", got[15:8], ((nfr - evenBase) % 2 == 0) ? 8'h9B : 8'hFF);
    chk("ts1", got[7:0], b);
  endtask
  always @(posedge sys_clk) if (ch1TxFrame === 1'b1) nfr++;
  always @(negedge sys_clk) begin
    if (ch1RxValid === 1'b1) chk("ch1 rx", ch1RxByte, sent1);
    if (ch2RxValid === 1'b1) chk("ch2 rx", ch2RxByte, sent2);
    if (ch1RxValid === 1'b1) next1 = 8'($urandom);
    if (ch2RxValid === 1'b1) next2 = 8'($urandom);
    gap2++;
    if (ch2TxFrame === 1'b1 && gap2 < 20000)
      chk("ch2 gap", 16'(gap2 inside {[16383:16385]}), 16'h0001);
    if (ch2TxFrame === 1'b1) gap2 = 0;
  end
  initial begin
    {rst_b, ch1InValid, ch2InValid, ch1LoopedPin} = '0;
    {ch1InData, ch2InData, next1, next2} = '0;
    ch2LoopedPin = 1'b1;
    evenBase = -1;
    gap2 = 99999;
    void'($urandom(32'hb56a));
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_frame();
    chk("modes", {ch1Looped, ch2Looped}, 16'h0001);
    @(posedge sys_clk);
    ch1LoopedPin <= 1'b1;
    ch2LoopedPin <= 1'b0;
    for (i = 0; i < 2; i++) begin
      a = (i == 0) ? 8'h00 : 8'($urandom);
      push(a);
      push((i == 0) ? 8'hFF : ~a);
      @(negedge sys_clk);
      chk("in ready", ch1InReady, 16'h0000);
      frame_check(a);
      frame_check((i == 0) ? 8'hFF : ~a);
      $display("payload pair %0d done", i);
    end
    frame_check(8'hFF);
    chk("modes kept", {ch1Looped, ch2Looped}, 16'h0001);
    chk("locked", {ch1RxLocked, ch2RxLocked}, 16'h0003);
    chk("ch2 in ready", ch2InReady, 16'h0001);
    $display("idle and mode test done");
    report_and_stop();
  end
endmodule
